// [core/ctw_top.sv]
// Processor control word register bank with AXI4-Lite access and memory interface
`timescale 1ns/100ps
module ctw_top #(
   parameter int ADDR_W = 22,
   parameter int DATA_W = ctw_pkg::DATA_W
) (
   input  wire logic                       clk_in,
   input  wire logic                       rst_n_in,
   input  wire logic [ctw_pkg::AXI_AW-1:0] s_axi_awaddr_in,
   input  wire logic                       s_axi_awvalid_in,
   output logic                            s_axi_awready_out,
   input  wire logic [31:0]                s_axi_wdata_in,
   input  wire logic [3:0]                 s_axi_wstrb_in,
   input  wire logic                       s_axi_wvalid_in,
   output logic                            s_axi_wready_out,
   output logic [1:0]                      s_axi_bresp_out,
   output logic                            s_axi_bvalid_out,
   input  wire logic                       s_axi_bready_in,
   input  wire logic [ctw_pkg::AXI_AW-1:0] s_axi_araddr_in,
   input  wire logic                       s_axi_arvalid_in,
   output logic                            s_axi_arready_out,
   output logic [31:0]                     s_axi_rdata_out,
   output logic [1:0]                      s_axi_rresp_out,
   output logic                            s_axi_rvalid_out,
   input  wire logic                       s_axi_rready_in,
   output logic [ADDR_W-1:0]               mem_addr_bus_out,
   output logic                            mem_addr_bus_oe_out,
   input  wire logic [DATA_W-1:0]          mem_data_bus_in,
   output logic [DATA_W-1:0]               mem_data_bus_out,
   output logic                            mem_data_bus_oe_out,
   output logic                            mem_rd_n_out,
   output logic                            mem_wr_n_out,
   output logic                            mem_grant_out,
   input  wire logic                       ext_ready_n_in,
   input  wire logic                       ext_irq_one_in,
   input  wire logic                       ext_irq_two_in,
   input  wire logic                       ser_out_empty_in,
   input  wire logic                       ser_in_full_in,
   input  wire logic                       par_out_empty_in,
   input  wire logic                       par_in_full_in,
   input  wire logic [7:0]                 parallel_io_pin_in,
   output logic [7:0]                      parallel_io_pin_out,
   output logic [7:0]                      parallel_io_pin_oe_out,
   output logic                            irq_out
);
   import ctw_pkg::*;

   localparam int SYNC_W = DATA_W + 11;
   localparam logic [SYNC_W-1:0] SYNC_RST = {1'b1, {(SYNC_W-1){1'b0}}};

   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction

   ctw_acc_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) acc ();

   // Register state
   logic [15:0]       ctrl_q;
   logic [15:0]       irq_stat_q;
   logic [15:0]       irq_mask_q;
   logic [ADDR_W-1:0] acc_addr_q;
   logic [DATA_W-1:0] acc_wdata_q;
   logic              acc_wr_q;
   logic              acc_part_b_q;
   logic              acc_req_q;
   logic              wide_pio_q;
   logic [7:0]        pio_out_q;

   // Pin synchronisers: ready, interrupt pins, parallel pins, data bus
   logic [SYNC_W-1:0] sync1_q;
   logic [SYNC_W-1:0] sync2_q;
   logic [SYNC_W-1:0] sync3_q;
   logic [SYNC_W-1:0] filt_q;
   logic              ready_n_f;
   logic              irq_one_f;
   logic              irq_two_f;
   logic [7:0]        pio_in_f;
   logic [DATA_W-1:0] dbus_f;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync1_q <= SYNC_RST;
         sync2_q <= SYNC_RST;
         sync3_q <= SYNC_RST;
         filt_q  <= SYNC_RST;
      end else begin
         sync1_q <= {ext_ready_n_in, ext_irq_one_in, ext_irq_two_in,
                     parallel_io_pin_in, mem_data_bus_in};
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         // A change counts once the second and third stages agree
         filt_q  <= (sync2_q & sync3_q) | (filt_q & (sync2_q | sync3_q));
      end
   end

   assign {ready_n_f, irq_one_f, irq_two_f, pio_in_f, dbus_f} = filt_q;

   // AXI4-Lite write channel
   logic              awready_q;
   logic              wready_q;
   logic              bvalid_q;
   logic [1:0]        bresp_q;
   logic              aw_hold_q;
   logic              w_hold_q;
   logic [AXI_AW-1:0] awaddr_q;
   logic [31:0]       wdata_q;
   logic [3:0]        wstrb_q;
   logic              aw_take;
   logic              w_take;
   logic              do_wr;
   logic              aw_hold_d;
   logic              w_hold_d;
   logic              bvalid_d;
   logic [AXI_AW-1:0] wr_addr;
   logic [31:0]       wr_data;
   logic [3:0]        wr_strb;
   logic              wr_hit;

   always_comb begin
      aw_take   = s_axi_awvalid_in && awready_q;
      w_take    = s_axi_wvalid_in && wready_q;
      do_wr     = (aw_hold_q || aw_take) && (w_hold_q || w_take) && !bvalid_q;
      aw_hold_d = (aw_hold_q || aw_take) && !do_wr;
      w_hold_d  = (w_hold_q || w_take) && !do_wr;
      bvalid_d  = do_wr || (bvalid_q && !s_axi_bready_in);
      wr_addr   = aw_take ? s_axi_awaddr_in : awaddr_q;
      wr_data   = w_take ? s_axi_wdata_in : wdata_q;
      wr_strb   = w_take ? s_axi_wstrb_in : wstrb_q;
      wr_hit    = (wr_addr == OFS_CTRL) || (wr_addr == OFS_IRQ_STAT)
                  || (wr_addr == OFS_IRQ_MASK) || (wr_addr == OFS_ACC_ADDR)
                  || (wr_addr == OFS_ACC_WDATA) || (wr_addr == OFS_ACC_CMD)
                  || (wr_addr == OFS_PIO_CTRL) || (wr_addr == OFS_PIO_OUT);
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         awaddr_q  <= '0;
         wdata_q   <= '0;
         wstrb_q   <= '0;
      end else begin
         aw_hold_q <= aw_hold_d;
         w_hold_q  <= w_hold_d;
         bvalid_q  <= bvalid_d;
         awready_q <= !aw_hold_d && !bvalid_d;
         wready_q  <= !w_hold_d && !bvalid_d;
         if (aw_take) begin
            awaddr_q <= s_axi_awaddr_in;
         end
         if (w_take) begin
            wdata_q <= s_axi_wdata_in;
            wstrb_q <= s_axi_wstrb_in;
         end
         if (do_wr) begin
            bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // Control word: holds its value until rewritten
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl_q <= CTRL_RST;
      end else if (do_wr && wr_addr == OFS_CTRL) begin
         ctrl_q <= 16'(merge_bytes({16'h0000, ctrl_q}, wr_data, wr_strb));
      end
   end

   // Access setup and launch
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         acc_addr_q   <= '0;
         acc_wdata_q  <= '0;
         acc_wr_q     <= 1'b0;
         acc_part_b_q <= 1'b0;
         acc_req_q    <= 1'b0;
      end else begin
         if (acc_req_q) begin
            acc_req_q <= 1'b0;
         end
         if (do_wr && wr_addr == OFS_ACC_ADDR) begin
            acc_addr_q <= ADDR_W'(merge_bytes(32'(acc_addr_q), wr_data, wr_strb));
         end
         if (do_wr && wr_addr == OFS_ACC_WDATA) begin
            acc_wdata_q <= DATA_W'(merge_bytes(32'(acc_wdata_q), wr_data, wr_strb));
         end
         // A start while an access runs is dropped
         if (do_wr && wr_addr == OFS_ACC_CMD && wr_strb[0] && wr_data[BIT_CMD_START]
             && !acc.busy && !acc_req_q) begin
            acc_req_q    <= 1'b1;
            acc_wr_q     <= wr_data[BIT_CMD_WRITE];
            acc_part_b_q <= wr_data[BIT_CMD_PART_B];
         end
      end
   end

   // Parallel pins
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wide_pio_q             <= 1'b0;
         pio_out_q              <= 8'h00;
         parallel_io_pin_out    <= 8'h00;
         parallel_io_pin_oe_out <= 8'h00;
      end else begin
         if (do_wr && wr_addr == OFS_PIO_CTRL && wr_strb[0]) begin
            wide_pio_q <= wr_data[BIT_WIDE_PIO];
         end
         if (do_wr && wr_addr == OFS_PIO_OUT && wr_strb[0]) begin
            pio_out_q <= wr_data[7:0];
         end
         parallel_io_pin_out       <= pio_out_q;
         parallel_io_pin_oe_out[3:0] <= {4{ctrl_q[BIT_PIO_LO_DIR] && !wide_pio_q}};
         parallel_io_pin_oe_out[7:4] <= {4{ctrl_q[BIT_PIO_HI_DIR] && !wide_pio_q}};
      end
   end

   // Interrupt sources in control word order, bits 15 down to 10
   logic [IRQ_SRC_W-1:0] src;
   logic [IRQ_SRC_W-1:0] src_q;
   logic [15:0]          ev;
   logic [15:0]          stat_clr;

   always_comb begin
      src = {irq_one_f, par_in_full_in, par_out_empty_in,
             ser_in_full_in, ser_out_empty_in, irq_two_f};
      ev  = 16'h0000;
      ev[LSB_IRQ_SRC +: IRQ_SRC_W] = src & ~src_q & ctrl_q[LSB_IRQ_SRC +: IRQ_SRC_W];
      ev[BIT_ACC_DONE] = acc.done;
      stat_clr = (do_wr && wr_addr == OFS_IRQ_STAT)
                 ? 16'(merge_bytes(32'h0000_0000, wr_data, wr_strb)) : 16'h0000;
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         src_q      <= '0;
         irq_stat_q <= IRQ_RST;
         irq_mask_q <= IRQ_RST;
         irq_out    <= 1'b0;
      end else begin
         src_q      <= src;
         // A new event wins over a clear in the same cycle
         irq_stat_q <= (irq_stat_q & ~stat_clr) | ev;
         if (do_wr && wr_addr == OFS_IRQ_MASK) begin
            irq_mask_q <= 16'(merge_bytes({16'h0000, irq_mask_q}, wr_data, wr_strb));
         end
         irq_out <= |(irq_stat_q & irq_mask_q);
      end
   end

   // AXI4-Lite read channel
   logic        arready_q;
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;
   logic [31:0] rd_val;
   logic        rd_hit;

   always_comb begin
      rd_hit = 1'b1;
      if (s_axi_araddr_in == OFS_CTRL) begin
         rd_val = {16'h0000, ctrl_q};
      end else if (s_axi_araddr_in == OFS_IRQ_STAT) begin
         rd_val = {16'h0000, irq_stat_q};
      end else if (s_axi_araddr_in == OFS_IRQ_MASK) begin
         rd_val = {16'h0000, irq_mask_q};
      end else if (s_axi_araddr_in == OFS_ACC_ADDR) begin
         rd_val = 32'(acc_addr_q);
      end else if (s_axi_araddr_in == OFS_ACC_WDATA) begin
         rd_val = 32'(acc_wdata_q);
      end else if (s_axi_araddr_in == OFS_ACC_CMD) begin
         rd_val = {29'h0, acc_part_b_q, acc_wr_q, 1'b0};
      end else if (s_axi_araddr_in == OFS_ACC_STAT) begin
         rd_val = {31'h0, acc.busy || acc_req_q};
      end else if (s_axi_araddr_in == OFS_ACC_RDATA) begin
         rd_val = 32'(acc.rdata);
      end else if (s_axi_araddr_in == OFS_PIO_CTRL) begin
         rd_val = {31'h0, wide_pio_q};
      end else if (s_axi_araddr_in == OFS_PIO_OUT) begin
         rd_val = {24'h0, pio_out_q};
      end else if (s_axi_araddr_in == OFS_PIO_IN) begin
         rd_val = {24'h0, pio_in_f};
      end else begin
         rd_val = 32'h0000_0000;
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= RESP_OKAY;
      end else if (s_axi_arvalid_in && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rdata_q   <= rd_val;
         rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready_in) begin
         rvalid_q  <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   assign s_axi_awready_out = awready_q;
   assign s_axi_wready_out  = wready_q;
   assign s_axi_bvalid_out  = bvalid_q;
   assign s_axi_bresp_out   = bresp_q;
   assign s_axi_arready_out = arready_q;
   assign s_axi_rvalid_out  = rvalid_q;
   assign s_axi_rdata_out   = rdata_q;
   assign s_axi_rresp_out   = rresp_q;

   assign acc.req     = acc_req_q;
   assign acc.wr      = acc_wr_q;
   assign acc.part_b  = acc_part_b_q;
   assign acc.addr    = acc_addr_q;
   assign acc.wdata   = acc_wdata_q;
   assign acc.ctrl    = ctrl_q;
   assign acc.ready_n = ready_n_f;
   assign acc.dbus    = dbus_f;

   ctw_mem_engine #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_engine (
      .clk_in              (clk_in),
      .rst_n_in            (rst_n_in),
      .acc                 (acc),
      .mem_addr_bus_out    (mem_addr_bus_out),
      .mem_addr_bus_oe_out (mem_addr_bus_oe_out),
      .mem_data_bus_out    (mem_data_bus_out),
      .mem_data_bus_oe_out (mem_data_bus_oe_out),
      .mem_rd_n_out        (mem_rd_n_out),
      .mem_wr_n_out        (mem_wr_n_out),
      .mem_grant_out       (mem_grant_out)
   );
endmodule

// [core/ctw_pkg.sv]
// Shared constants for the control word block: offsets, fields, resets, counts
package ctw_pkg;
   localparam int DATA_W = 32;
   localparam int AXI_AW = 8;
   // Register byte offsets
   localparam logic [AXI_AW-1:0] OFS_CTRL      = 8'h00;
   localparam logic [AXI_AW-1:0] OFS_IRQ_STAT  = 8'h04;
   localparam logic [AXI_AW-1:0] OFS_IRQ_MASK  = 8'h08;
   localparam logic [AXI_AW-1:0] OFS_ACC_ADDR  = 8'h0c;
   localparam logic [AXI_AW-1:0] OFS_ACC_WDATA = 8'h10;
   localparam logic [AXI_AW-1:0] OFS_ACC_CMD   = 8'h14;
   localparam logic [AXI_AW-1:0] OFS_ACC_STAT  = 8'h18;
   localparam logic [AXI_AW-1:0] OFS_ACC_RDATA = 8'h1c;
   localparam logic [AXI_AW-1:0] OFS_PIO_CTRL  = 8'h20;
   localparam logic [AXI_AW-1:0] OFS_PIO_OUT   = 8'h24;
   localparam logic [AXI_AW-1:0] OFS_PIO_IN    = 8'h28;
   // Control word field positions, then PIO control, command and status bit positions
   localparam int BIT_B_WAIT_EN   = 0;
   localparam int BIT_A_WAIT_EN   = 1;
   localparam int LSB_B_WAIT_CNT  = 2;
   localparam int LSB_A_WAIT_CNT  = 4;
   localparam int BIT_PIO_LO_DIR  = 6;
   localparam int BIT_PIO_HI_DIR  = 7;
   localparam int BIT_GRANT_SEL   = 8;
   localparam int BIT_FORCE_FORCE_ACCESS_PENDING  = 9;
   localparam int LSB_IRQ_SRC     = 10;
   localparam int IRQ_SRC_W       = 6;
   localparam int BIT_WIDE_PIO    = 0;
   localparam int BIT_CMD_START   = 0;
   localparam int BIT_CMD_WRITE   = 1;
   localparam int BIT_CMD_PART_B  = 2;
   localparam int BIT_ACC_DONE    = 0;
   // Reset values
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [15:0] IRQ_RST  = 16'h0000;
   // Wait-state timing: one wait state lasts one clock period
   localparam int CLK_PERIOD_PS     = 10000;
   localparam int WAIT_STATE_PS     = CLK_PERIOD_PS;
   localparam int WAIT_STATE_CYC    = (WAIT_STATE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WAIT_MAX_CLK_PS   = 12500;
   localparam logic [1:0] WCODE_READY = 2'b11;
   localparam int READY_MIN_WAITS    = 2;
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_ACCESS = 3'b010,
      ST_DONE   = 3'b100
   } ctw_state_t;
endpackage

// [core/ctw_acc_if.sv]
// Access request and configuration channel between control logic and memory engine
`timescale 1ns/100ps
interface ctw_acc_if #(parameter int ADDR_W = 22, parameter int DATA_W = 32);
   logic              req;
   logic              wr;
   logic              part_b;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic [15:0]       ctrl;
   logic              ready_n;
   logic [DATA_W-1:0] dbus;
   logic              busy;
   logic              done;
   logic [DATA_W-1:0] rdata;
   modport ctl (output req, wr, part_b, addr, wdata, ctrl, ready_n, dbus,
                input busy, done, rdata);
   modport eng (input req, wr, part_b, addr, wdata, ctrl, ready_n, dbus,
                output busy, done, rdata);
endinterface

// [core/ctw_mem_engine.sv]
// External memory access engine with wait-state generation and grant pin
`timescale 1ns/100ps
module ctw_mem_engine #(
   parameter int ADDR_W = 22,
   parameter int DATA_W = 32
) (
   input  wire logic              clk_in,
   input  wire logic              rst_n_in,
   ctw_acc_if.eng                 acc,
   output logic [ADDR_W-1:0]      mem_addr_bus_out,
   output logic                   mem_addr_bus_oe_out,
   output logic [DATA_W-1:0]      mem_data_bus_out,
   output logic                   mem_data_bus_oe_out,
   output logic                   mem_rd_n_out,
   output logic                   mem_wr_n_out,
   output logic                   mem_grant_out
);
   import ctw_pkg::*;

   ctw_state_t state_q;
   logic [2:0] cnt_q;
   logic       ready_mode_q;
   logic       wr_q;
   logic [1:0] code;
   logic       wen;
   logic [2:0] waits;

   // Settings are sampled when an access starts
   always_comb begin
      wen  = acc.part_b ? acc.ctrl[BIT_B_WAIT_EN] : acc.ctrl[BIT_A_WAIT_EN];
      code = acc.part_b ? acc.ctrl[LSB_B_WAIT_CNT +: 2] : acc.ctrl[LSB_A_WAIT_CNT +: 2];
      if (!wen) begin
         waits = 3'd0;
      end else if (code == WCODE_READY) begin
         waits = 3'(READY_MIN_WAITS * WAIT_STATE_CYC);
      end else begin
         waits = 3'((int'(code) + 1) * WAIT_STATE_CYC);
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q      <= ST_IDLE;
         cnt_q        <= 3'd0;
         ready_mode_q <= 1'b0;
         wr_q         <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (acc.req) begin
                  state_q      <= ST_ACCESS;
                  cnt_q        <= waits;
                  ready_mode_q <= wen && (code == WCODE_READY);
                  wr_q         <= acc.wr;
               end
            end
            ST_ACCESS: begin
               if (cnt_q != 3'd0) begin
                  cnt_q <= cnt_q - 3'd1;
               end else if (!ready_mode_q || !acc.ready_n) begin
                  state_q <= ST_DONE;
               end
            end
            ST_DONE: begin
               state_q <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Pin drive
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mem_addr_bus_out    <= '0;
         mem_addr_bus_oe_out <= 1'b0;
         mem_data_bus_out    <= '0;
         mem_data_bus_oe_out <= 1'b0;
         mem_rd_n_out        <= 1'b1;
         mem_wr_n_out        <= 1'b1;
      end else if (state_q == ST_IDLE && acc.req) begin
         mem_addr_bus_out    <= acc.addr;
         mem_addr_bus_oe_out <= 1'b1;
         mem_data_bus_out    <= acc.wdata;
         mem_data_bus_oe_out <= acc.wr;
         mem_rd_n_out        <= acc.wr;
         mem_wr_n_out        <= !acc.wr;
      end else if (state_q == ST_ACCESS && cnt_q == 3'd0 && (!ready_mode_q || !acc.ready_n)) begin
         mem_addr_bus_oe_out <= 1'b0;
         mem_data_bus_oe_out <= 1'b0;
         mem_rd_n_out        <= 1'b1;
         mem_wr_n_out        <= 1'b1;
      end
   end

   // Grant pin: output enable or access-pending indicator
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mem_grant_out <= 1'b1;
      end else if (acc.ctrl[BIT_GRANT_SEL]) begin
         mem_grant_out <= !(acc.ctrl[BIT_FORCE_FORCE_ACCESS_PENDING] || acc.req
                            || state_q != ST_IDLE);
      end else begin
         mem_grant_out <= !(state_q == ST_IDLE && acc.req && !acc.wr)
                          && !(state_q == ST_ACCESS && !wr_q
                               && !(cnt_q == 3'd0 && (!ready_mode_q || !acc.ready_n)));
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         acc.rdata <= '0;
         acc.done  <= 1'b0;
      end else begin
         acc.done <= (state_q == ST_ACCESS) && cnt_q == 3'd0
                     && (!ready_mode_q || !acc.ready_n);
         if (state_q == ST_ACCESS && cnt_q == 3'd0 && !wr_q) begin
            acc.rdata <= acc.dbus;
         end
      end
   end

   assign acc.busy = (state_q != ST_IDLE);
endmodule

// [testbench/ctw_monitor.sv]
// Concurrent checks on the control word block's pins
`timescale 1ns/100ps
module ctw_monitor (
   input wire logic clk_in, rst_n_in, mem_rd_n_out, mem_wr_n_out, mem_addr_bus_oe_out,
   input wire logic mem_data_bus_oe_out, s_axi_bvalid_out, s_axi_bready_in,
   input wire logic s_axi_awready_out, s_axi_rvalid_out, s_axi_rready_in, s_axi_arready_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_wr_go; $fell(mem_wr_n_out); endsequence
   sequence s_rd_go; $fell(mem_rd_n_out); endsequence
   property p_wr_oe; !mem_wr_n_out |-> mem_data_bus_oe_out && mem_addr_bus_oe_out; endproperty
   a_wr_oe: assert property (p_wr_oe) else $error("write strobe without drive");
   property p_rd_oe; !mem_rd_n_out |-> !mem_data_bus_oe_out && mem_addr_bus_oe_out; endproperty
   a_rd_oe: assert property (p_rd_oe) else $error("data driven during read");
   property p_excl; !(!mem_rd_n_out && !mem_wr_n_out); endproperty
   a_excl: assert property (p_excl) else $error("both strobes low");
   property p_wr_end; s_wr_go |-> ##[1:60] $rose(mem_wr_n_out); endproperty
   a_wr_end: assert property (p_wr_end) else $error("write access too long");
   property p_rd_end; s_rd_go |-> ##[1:60] $rose(mem_rd_n_out); endproperty
   a_rd_end: assert property (p_rd_end) else $error("read access too long");
   property p_rel; $rose(mem_wr_n_out) |-> !mem_data_bus_oe_out; endproperty
   a_rel: assert property (p_rel) else $error("data bus kept after write");
   property p_b_hold; s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out; endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_r_hold; s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out; endproperty
   a_r_hold: assert property (p_r_hold) else $error("read response dropped");
   property p_b_busy; s_axi_bvalid_out |-> !s_axi_awready_out; endproperty
   a_b_busy: assert property (p_b_busy) else $error("address taken while busy");
   property p_r_busy; s_axi_rvalid_out |-> !s_axi_arready_out; endproperty
   a_r_busy: assert property (p_r_busy) else $error("read taken while busy");
endmodule

// [testbench/ctw_mem_model.sv]
// Behavioural external memory answering the block's access strobes
`timescale 1ns/100ps
module ctw_mem_model (
   input  wire logic        clk_in, rd_n_in, wr_n_in, oe_in,
   input  wire logic [21:0] addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic [7:0]  dly_in,
   output logic             ready_n_out,
   output logic [31:0]      data_out
);
   logic [31:0] mem [16];
   logic [31:0] last_q = 0;
   int          n = 0;
   wire         idle = rd_n_in & wr_n_in;
   always @(posedge clk_in) begin
      n <= idle ? 0 : n + 1;
      last_q <= data_out;
      if (!wr_n_in) mem[addr_in[3:0]] <= wdata_in;
   end
   // Ready held off until the programmed delay has run
   assign ready_n_out = idle || n < dly_in;
   // Released bus shows a changing pattern
   assign data_out = oe_in ? wdata_in : !rd_n_in ? mem[addr_in[3:0]] : ~last_q;
endmodule

// [testbench/tb_top.sv]
// Register-level regression of the control word block
`timescale 1ns/100ps
module tb_top;
   import ctw_pkg::*;
   logic clk_in = 0, rst_n_in = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
   logic [7:0] awaddr = 0, araddr = 0, dly = 0, pio_oe, pio_o;
   logic [31:0] wdata = 0, d, rdata, dout, din;
   logic [1:0] r, bresp, rresp;
   logic awready, wready, bvalid, arready, rvalid, rd_n, wr_n, aoe, doe, grant, irq, rdy_n;
   logic [21:0] addr;
   logic [5:0] src = 0;
   int mismatches = 0, checks = 0, len = 0;
   always #5 clk_in = ~clk_in;
   always @(posedge clk_in) if (!(rd_n & wr_n)) len++;
   ctw_top ctw_top_i (.clk_in, .rst_n_in, .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv),
      .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf),
      .s_axi_wvalid_in(wv), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
      .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
      .s_axi_arvalid_in(arv), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
      .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
      .mem_addr_bus_out(addr), .mem_addr_bus_oe_out(aoe), .mem_data_bus_in(din),
      .mem_data_bus_out(dout), .mem_data_bus_oe_out(doe), .mem_rd_n_out(rd_n),
      .mem_wr_n_out(wr_n), .mem_grant_out(grant), .ext_ready_n_in(rdy_n),
      .ext_irq_one_in(src[5]), .ext_irq_two_in(src[0]), .ser_out_empty_in(src[1]),
      .ser_in_full_in(src[2]), .par_out_empty_in(src[3]), .par_in_full_in(src[4]),
      .parallel_io_pin_in(8'h5a), .parallel_io_pin_out(pio_o), .parallel_io_pin_oe_out(pio_oe),
      .irq_out(irq));
   ctw_mem_model ctw_mem_model_i (.clk_in, .rd_n_in(rd_n), .wr_n_in(wr_n), .oe_in(doe),
      .addr_in(addr), .wdata_in(dout), .dly_in(dly), .ready_n_out(rdy_n), .data_out(din));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         mismatches++;
         $display("CHECK FAILED %0t saw %h want %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_in);
      {awaddr, wdata, awv, wv, bready} <= {a, v, 3'b111};
      do begin
         @(posedge clk_in);
         if (awready) awv <= 0;
         if (wready) wv <= 0;
         if (bvalid) bready <= 0;
      end while (awv | wv | bready);
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_in);
      {araddr, arv, rready} <= {a, 2'b11};
      do begin
         @(posedge clk_in);
         if (arready) arv <= 0;
         if (rvalid) {d, r, rready} <= {rdata, rresp, 1'b0};
      end while (arv | rready);
   endtask
   task automatic acc(input logic [2:0] c);
      len = 0;
      wr(OFS_ACC_CMD, {29'h0, c});
      repeat (50) @(posedge clk_in);
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      #100us;
      mismatches++;
      give_verdict;
   end
   initial begin
      repeat (8) @(posedge clk_in);
      rst_n_in <= 1;
      rd(OFS_CTRL);
      chk(d, 0);
      rd(8'h3c);
      chk(r, RESP_SLVERR);
      wr(OFS_ACC_ADDR, 5);
      wr(OFS_ACC_WDATA, 32'h1234abcd);
      for (int p = 0; p < 2; p++) begin
         for (int c = 0; c < 5; c++) begin
            wr(OFS_CTRL, c > 3 ? 0 : (p ? 1 : 2) | c << (p ? 2 : 4));
            acc({p[0], 2'b11});
            chk(c == 3 ? 32'(len >= 3) : len, c > 2 ? 1 : c + 2);
         end
      end
      dly <= 8;
      wr(OFS_CTRL, 16'h0032);
      acc(3'b011);
      chk(len > 8, 1);
      dly <= 0;
      // Ready-paced read lets the bus cross the pin synchroniser before capture
      wr(OFS_CTRL, 16'h000d);
      acc(3'b101);
      rd(OFS_ACC_RDATA);
      chk(d, 32'h1234abcd);
      rd(OFS_CTRL);
      chk(d, 16'h000d);
      wr(OFS_CTRL, 16'h00c0);
      chk(pio_oe, 8'hff);
      wr(OFS_PIO_CTRL, 1);
      chk(pio_oe, 0);
      wr(OFS_PIO_CTRL, 0);
      wr(OFS_CTRL, 16'h0040);
      chk(pio_oe, 8'h0f);
      wr(OFS_PIO_OUT, 8'h3c);
      chk(pio_o, 8'h3c);
      rd(OFS_PIO_IN);
      chk(d, 8'h5a);
      wr(OFS_CTRL, 16'h0300);
      chk(grant, 0);
      wr(OFS_CTRL, 16'h0100);
      chk(grant, 1);
      wr(OFS_CTRL, 16'h0200);
      chk(grant, 1);
      for (int i = 0; i < 6; i++) begin
         wr(OFS_IRQ_STAT, 32'hffff);
         wr(OFS_CTRL, 1 << (10 + i));
         wr(OFS_IRQ_MASK, 1 << (10 + i));
         src[i] <= 1;
         repeat (8) @(posedge clk_in);
         chk(irq, 1);
         rd(OFS_IRQ_STAT);
         chk(d, 1 << (10 + i));
         wr(OFS_IRQ_MASK, 0);
         chk(irq, 0);
         src[i] <= 0;
         wr(OFS_IRQ_STAT, 1 << (10 + i));
         rd(OFS_IRQ_STAT);
         chk(d, 0);
      end
      give_verdict;
   end
endmodule
bind ctw_top ctw_monitor ctw_monitor_i (.*);
